//--- rtl/ubr_map.svh
`ifndef UBR_MAP_SVH
`define UBR_MAP_SVH
// ----------------------------------------
// mode codes
// ----------------------------------------
`define UBR_MODE_DALI_TOP 3'h4
`define UBR_MODE_DMX 4'ha
`define UBR_MODE_LIN_CLIENT 4'hb
`define UBR_MODE_LIN_HOST 4'hc
// ----------------------------------------
// timing counts and reset values
// ----------------------------------------
`define UBR_BASE_LAST_HI 4'h3
`define UBR_BASE_LAST_NORM 4'hf
`define UBR_ABD_LAST 3'h7
`define UBR_DIV_RESET 16'h0000
`define UBR_SYNC_FALLS 3'h5
`define UBR_SYNC_RISES 3'h5
`define UBR_BREAK_ZEROS 12
`define UBR_CHAR_BITS 5'h0a
`define UBR_BREAK_CHAR_BITS 5'h18
`endif

//--- rtl/ubr_pkg.sv
package ubr_pkg;
  typedef enum logic [2:0] {ABD_OFF, ABD_SKIP_BREAK, ABD_ARMED, ABD_MEASURE, ABD_TAIL} ubr_abd_e;
  typedef struct packed {
    logic [3:0] preCnt;
    logic [2:0] abdCnt;
    logic [15:0] brgCnt;
  } ubr_timer_s;
  typedef struct packed {
    logic busy;
    logic withBreak;
    logic [4:0] bitsLeft;
    logic [23:0] shift;
  } ubr_tx_s;
  typedef struct packed {
    ubr_abd_e abd;
    logic [15:0] divisor;
    logic [15:0] measCnt;
    logic measOvf;
    logic [2:0] fallCnt;
    logic [2:0] riseCnt;
    logic autobaud_enable;
    logic doneFlag;
    logic ovfFlag;
    logic rxIdle;
    logic wakeEn;
    logic wakeFlag;
    logic wakeSeen;
    logic sendBrk;
    logic rxPrev;
  } ubr_core_s;
endpackage

//--- rtl/ubr_baud_timer.sv
`timescale 1ns/1ps
`include "ubr_map.svh"
module ubr_baud_timer #(
  parameter int DIV_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic speedSelect,
  input wire logic timerRestart,
  input wire logic [15:0] divisor,
  output logic bitTick,
  output logic abdTick
);
  generate
    if (DIV_W != 16) begin : g_chk
      $error("ubr_baud_timer: divisor width must be 16");
    end
  endgenerate

  ubr_pkg::ubr_timer_s st_ff;
  ubr_pkg::ubr_timer_s nxt_st;
  logic baseTick;

  // ----------------------------------------
  // prescaler, abd divider and divisor timer
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    baseTick = st_ff.preCnt == (speedSelect ? `UBR_BASE_LAST_HI : `UBR_BASE_LAST_NORM);
    bitTick = baseTick && (st_ff.brgCnt == divisor);
    abdTick = baseTick && (st_ff.abdCnt == `UBR_ABD_LAST);
    nxt_st.preCnt = baseTick ? 4'h0 : st_ff.preCnt + 4'h1;
    if (baseTick) begin
      nxt_st.abdCnt = st_ff.abdCnt + 3'h1;
      nxt_st.brgCnt = bitTick ? 16'h0000 : st_ff.brgCnt + 16'h0001;
    end
    // new divisor takes effect at once, no wait for the old period
    if (timerRestart) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

//--- rtl/ubr_break_tx.sv
`timescale 1ns/1ps
`include "ubr_map.svh"
module ubr_break_tx (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic bitTick,
  input wire logic transmitEnable,
  input wire logic sendBreakRequest,
  input wire logic breakForceOverride,
  input wire logic txPolarityInvert,
  input wire logic txBufferWrite,
  input wire logic [7:0] txBufferData,
  output logic txOut,
  output logic transmitIdleFlag,
  output logic breakStopDone
);
  ubr_pkg::ubr_tx_s st_ff;
  ubr_pkg::ubr_tx_s nxt_st;
  logic txLine;

  // ----------------------------------------
  // shifter: optional break frame, then the char
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    breakStopDone = 1'b0;
    if (!st_ff.busy) begin
      // no holding buffer: a write while busy is dropped
      if (txBufferWrite && transmitEnable) begin
        nxt_st.busy = 1'b1;
        nxt_st.withBreak = sendBreakRequest;
        if (sendBreakRequest) begin
          nxt_st.shift = {1'b1, txBufferData, 1'b0, 1'b1, {`UBR_BREAK_ZEROS{1'b0}}, 1'b0};
          nxt_st.bitsLeft = `UBR_BREAK_CHAR_BITS;
        end else begin
          nxt_st.shift = {14'h3fff, 1'b1, txBufferData, 1'b0};
          nxt_st.bitsLeft = `UBR_CHAR_BITS;
        end
      end
    end else if (bitTick) begin
      nxt_st.shift = {1'b1, st_ff.shift[23:1]};
      nxt_st.bitsLeft = st_ff.bitsLeft - 5'h01;
      // break stop bit ends when the ten char bits remain
      if (st_ff.withBreak && st_ff.bitsLeft == `UBR_CHAR_BITS + 5'h01) begin
        breakStopDone = 1'b1;
      end
      if (st_ff.bitsLeft == 5'h01) begin
        nxt_st.busy = 1'b0;
        nxt_st.withBreak = 1'b0;
      end
    end
    txLine = breakForceOverride ? 1'b0 : (st_ff.busy ? st_ff.shift[0] : 1'b1);
    transmitIdleFlag = !st_ff.busy;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      txOut <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      txOut <= txLine ^ txPolarityInvert;
    end
  end
endmodule

//--- rtl/ubr_baud_core.sv
`timescale 1ns/1ps
`include "ubr_map.svh"
module ubr_baud_core (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] uartMode,
  input wire logic baudSpeedSelect,
  input wire logic baudDivisorHighWr,
  input wire logic baudDivisorLowWr,
  input wire logic [7:0] divisorWrData,
  output logic [7:0] baudDivisorHigh,
  output logic [7:0] baudDivisorLow,
  input wire logic autobaudEnableSet,
  input wire logic autobaudEnableClr,
  output logic autobaudEnable,
  input wire logic autobaudDoneClr,
  output logic autobaudDoneFlag,
  input wire logic autobaudOverflowClr,
  output logic autobaudOverflowFlag,
  input wire logic autobaudOverflowIrqEnable,
  input wire logic uartErrorIrqEnable,
  input wire logic peripheralIrqEnable,
  input wire logic globalIrqEnable,
  output logic autobaudOverflowIrq,
  input wire logic wakeEnableSet,
  input wire logic wakeEnableClr,
  output logic wakeEnable,
  input wire logic wakeFlagClr,
  output logic wakeFlag,
  input wire logic uartIrqEnable,
  output logic wakeIrq,
  output logic wakeRequest,
  input wire logic rxIn,
  input wire logic rxPolarityInvert,
  output logic receiveIdleFlag,
  output logic receiverHold,
  output logic baudTick,
  input wire logic transmitEnable,
  input wire logic sendBreakSet,
  input wire logic sendBreakClr,
  output logic sendBreakRequest,
  input wire logic breakForceOverride,
  input wire logic txPolarityInvert,
  input wire logic transmitBufferWrite,
  input wire logic [7:0] transmitBufferData,
  output logic txOut,
  output logic transmitIdleFlag
);
  ubr_pkg::ubr_core_s st_ff;
  ubr_pkg::ubr_core_s nxt_st;

  logic rxLine;
  logic rxFall;
  logic rxRise;
  logic asyncMode;
  logic breakBlocked;
  logic wakeActive;
  logic abdTick;
  logic bitTick;
  logic timerRestart;
  logic breakStopDone;
  logic abdLoad;
  logic [15:0] abdResult;

  // ----------------------------------------
  // line and mode decode
  // ----------------------------------------
  assign rxLine = rxIn ^ rxPolarityInvert;
  assign rxFall = st_ff.rxPrev && !rxLine;
  assign rxRise = !st_ff.rxPrev && rxLine;
  // LIN measures by itself and DALI ignores the enable
  assign asyncMode = !uartMode[3];
  // LIN and DMX make their own break; DALI keeps the bit read-only
  assign breakBlocked = uartMode[3];
  assign wakeActive = st_ff.wakeEn && uartIrqEnable;
  // count n+1 measuring ticks over eight bits equals divisor n
  assign abdResult = (st_ff.measCnt == 16'h0000) ? 16'h0000 : st_ff.measCnt - 16'h0001;
  assign abdLoad = (st_ff.abd == ubr_pkg::ABD_MEASURE) && rxFall && !st_ff.measOvf
                   && (st_ff.fallCnt + 3'h1 == `UBR_SYNC_FALLS);
  assign timerRestart = baudDivisorHighWr || baudDivisorLowWr || abdLoad;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rxPrev = rxLine;

    // software divisor writes; a completing measurement wins the cycle
    if (baudDivisorHighWr) begin
      nxt_st.divisor[15:8] = divisorWrData;
    end
    if (baudDivisorLowWr) begin
      nxt_st.divisor[7:0] = divisorWrData;
    end

    // flag clears first, so a same-cycle set below wins
    if (autobaudDoneClr) begin
      nxt_st.doneFlag = 1'b0;
    end
    if (autobaudOverflowClr) begin
      nxt_st.ovfFlag = 1'b0;
    end
    if (wakeFlagClr) begin
      nxt_st.wakeFlag = 1'b0;
    end

    // send break control
    if (sendBreakClr || breakStopDone) begin
      nxt_st.sendBrk = 1'b0;
    end
    if (sendBreakSet && !breakBlocked) begin
      nxt_st.sendBrk = 1'b1;
    end

    // wake on break
    if (wakeEnableClr) begin
      nxt_st.wakeEn = 1'b0;
      nxt_st.wakeSeen = 1'b0;
    end
    if (wakeEnableSet) begin
      nxt_st.wakeEn = 1'b1;
    end
    if (wakeActive) begin
      if (!st_ff.wakeSeen && !rxLine) begin
        // any low level counts, so a non-zero char wakes at its start bit
        nxt_st.wakeSeen = 1'b1;
        nxt_st.wakeFlag = 1'b1;
      end else if (st_ff.wakeSeen && rxLine) begin
        nxt_st.wakeEn = 1'b0;
        nxt_st.wakeSeen = 1'b0;
      end
    end

    // auto-baud enable
    if (autobaudEnableClr) begin
      nxt_st.autobaud_enable = 1'b0;
    end
    if (autobaudEnableSet && asyncMode) begin
      nxt_st.autobaud_enable = 1'b1;
    end

    // auto-baud sequence
    unique case (st_ff.abd)
      ubr_pkg::ABD_OFF: begin
        if (st_ff.autobaud_enable && asyncMode) begin
          nxt_st.abd = st_ff.wakeEn ? ubr_pkg::ABD_SKIP_BREAK : ubr_pkg::ABD_ARMED;
        end
      end
      ubr_pkg::ABD_SKIP_BREAK: begin
        // the break ends when hardware drops wake enable
        if (!st_ff.wakeEn) begin
          nxt_st.abd = ubr_pkg::ABD_ARMED;
        end
      end
      ubr_pkg::ABD_ARMED: begin
        if (rxFall) begin
          nxt_st.abd = ubr_pkg::ABD_MEASURE;
          nxt_st.measCnt = 16'h0000;
          nxt_st.measOvf = 1'b0;
          nxt_st.fallCnt = 3'h1;
          nxt_st.riseCnt = 3'h0;
          nxt_st.rxIdle = 1'b0;
        end
      end
      ubr_pkg::ABD_MEASURE: begin
        if (abdTick) begin
          if (st_ff.measCnt == 16'hffff) begin
            nxt_st.measOvf = 1'b1;
            nxt_st.ovfFlag = 1'b1;
          end else begin
            nxt_st.measCnt = st_ff.measCnt + 16'h0001;
          end
        end
        if (rxRise) begin
          nxt_st.riseCnt = st_ff.riseCnt + 3'h1;
        end
        if (rxFall) begin
          nxt_st.fallCnt = st_ff.fallCnt + 3'h1;
          if (st_ff.fallCnt + 3'h1 == `UBR_SYNC_FALLS) begin
            nxt_st.autobaud_enable = 1'b0;
            nxt_st.doneFlag = 1'b1;
            nxt_st.abd = ubr_pkg::ABD_TAIL;
          end
        end
      end
      ubr_pkg::ABD_TAIL: begin
        if (rxRise) begin
          nxt_st.riseCnt = st_ff.riseCnt + 3'h1;
          if (st_ff.riseCnt + 3'h1 == `UBR_SYNC_RISES) begin
            nxt_st.rxIdle = 1'b1;
            nxt_st.abd = ubr_pkg::ABD_OFF;
          end
        end
      end
    endcase

    // divisor stays untouched unless the measurement is clean
    if (abdLoad) begin
      nxt_st.divisor = abdResult;
    end

    // software abort: enable dropped before completion
    if (!st_ff.autobaud_enable && st_ff.abd != ubr_pkg::ABD_OFF && st_ff.abd != ubr_pkg::ABD_TAIL) begin
      nxt_st.abd = ubr_pkg::ABD_OFF;
      nxt_st.rxIdle = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{abd: ubr_pkg::ABD_OFF, divisor: `UBR_DIV_RESET, measCnt: 16'h0000, measOvf: 1'b0,
                 fallCnt: 3'h0, riseCnt: 3'h0, autobaud_enable: 1'b0, doneFlag: 1'b0, ovfFlag: 1'b0,
                 rxIdle: 1'b1, wakeEn: 1'b0, wakeFlag: 1'b0, wakeSeen: 1'b0, sendBrk: 1'b0,
                 rxPrev: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign baudDivisorHigh = st_ff.divisor[15:8];
  assign baudDivisorLow = st_ff.divisor[7:0];
  assign autobaudEnable = st_ff.autobaud_enable;
  assign autobaudDoneFlag = st_ff.doneFlag;
  assign autobaudOverflowFlag = st_ff.ovfFlag;
  assign autobaudOverflowIrq = st_ff.ovfFlag && autobaudOverflowIrqEnable && uartErrorIrqEnable
                               && peripheralIrqEnable && globalIrqEnable;
  assign wakeEnable = st_ff.wakeEn;
  assign wakeFlag = st_ff.wakeFlag;
  assign wakeIrq = st_ff.wakeFlag && uartIrqEnable && peripheralIrqEnable && globalIrqEnable;
  // combinational from the pin so it still works with the clock stopped
  assign wakeRequest = wakeActive && (!rxLine || st_ff.wakeFlag);
  assign receiveIdleFlag = st_ff.rxIdle;
  assign receiverHold = wakeActive || (st_ff.abd != ubr_pkg::ABD_OFF);
  assign sendBreakRequest = st_ff.sendBrk;
  assign baudTick = bitTick;

  // ----------------------------------------
  // timer and transmit path
  // ----------------------------------------
  ubr_baud_timer #(
    .DIV_W(16)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .speedSelect(baudSpeedSelect),
    .timerRestart(timerRestart),
    .divisor(st_ff.divisor),
    .bitTick(bitTick),
    .abdTick(abdTick)
  );

  ubr_break_tx u_tx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .bitTick(bitTick),
    .transmitEnable(transmitEnable),
    .sendBreakRequest(st_ff.sendBrk),
    .breakForceOverride(breakForceOverride),
    .txPolarityInvert(txPolarityInvert),
    .txBufferWrite(transmitBufferWrite),
    .txBufferData(transmitBufferData),
    .txOut(txOut),
    .transmitIdleFlag(transmitIdleFlag),
    .breakStopDone(breakStopDone)
  );
endmodule

//--- sim/ubr_baud_monitor.sv
`timescale 1ns/1ps
module ubr_baud_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] uartMode,
  input wire logic baudDivisorHighWr,
  input wire logic baudDivisorLowWr,
  input wire logic [7:0] baudDivisorHigh,
  input wire logic [7:0] baudDivisorLow,
  input wire logic autobaudEnable,
  input wire logic autobaudDoneFlag,
  input wire logic autobaudOverflowFlag,
  input wire logic autobaudOverflowIrqEnable,
  input wire logic uartErrorIrqEnable,
  input wire logic peripheralIrqEnable,
  input wire logic globalIrqEnable,
  input wire logic autobaudOverflowIrq,
  input wire logic wakeEnableSet,
  input wire logic wakeEnable,
  input wire logic wakeFlagClr,
  input wire logic wakeFlag,
  input wire logic uartIrqEnable,
  input wire logic wakeIrq,
  input wire logic rxIn,
  input wire logic receiveIdleFlag,
  input wire logic sendBreakRequest,
  input wire logic breakForceOverride,
  input wire logic txPolarityInvert,
  input wire logic txOut
);
  wire logic [15:0] div = {baudDivisorHigh, baudDivisorLow};
  wire logic irqGate = peripheralIrqEnable & globalIrqEnable;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_ovf_irq_gate: assert property (
    autobaudOverflowIrq == (autobaudOverflowFlag & autobaudOverflowIrqEnable & uartErrorIrqEnable & irqGate))
    else $error("overflow interrupt gating wrong");
  a_wake_irq_gate: assert property (
    wakeIrq == (wakeFlag & uartIrqEnable & irqGate)) else $error("wake interrupt gating wrong");
  a_done_ends_abd: assert property (
    $rose(autobaudDoneFlag) |-> $past(autobaudEnable) && !autobaudEnable) else $error("done without ending");
  a_div_source: assert property (
    !$stable(div) |-> $past(baudDivisorHighWr | baudDivisorLowWr) || $rose(autobaudDoneFlag))
    else $error("divisor changed without cause");
  a_ovf_keeps_div: assert property (
    $rose(autobaudDoneFlag) && autobaudOverflowFlag |-> $stable(div)) else $error("overflow loaded divisor");
  a_idle_on_fall: assert property (
    $fell(receiveIdleFlag) |-> $past(autobaudEnable) && !$past(rxIn) && $past(rxIn, 2))
    else $error("idle flag fell without rx fall");
  a_wake_flag_set: assert property (
    wakeEnable && uartIrqEnable && !rxIn && !wakeFlagClr |=> wakeFlag) else $error("wake flag not set");
  a_wake_en_drop: assert property (
    wakeEnable && uartIrqEnable && $rose(rxIn) && !wakeEnableSet |=> !wakeEnable) else $error("wake enable kept");
  a_break_forced: assert property (
    breakForceOverride |=> txOut == txPolarityInvert) else $error("tx not forced");
  a_mode_refuse: assert property (
    uartMode[3] && !autobaudEnable && !sendBreakRequest |=> !autobaudEnable && !sendBreakRequest)
    else $error("set taken in protocol mode");
  c_abd_done: cover property ($rose(autobaudDoneFlag));
  c_wake_end: cover property ($fell(wakeEnable) && wakeFlag);
  c_break_end: cover property ($fell(sendBreakRequest));
endmodule
bind ubr_baud_core ubr_baud_monitor i_ubr_baud_monitor (
  .core_clk, .rst_n, .uartMode, .baudDivisorHighWr, .baudDivisorLowWr, .baudDivisorHigh, .baudDivisorLow,
  .autobaudEnable, .autobaudDoneFlag, .autobaudOverflowFlag, .autobaudOverflowIrqEnable, .uartErrorIrqEnable,
  .peripheralIrqEnable, .globalIrqEnable, .autobaudOverflowIrq, .wakeEnableSet, .wakeEnable, .wakeFlagClr,
  .wakeFlag, .uartIrqEnable, .wakeIrq, .rxIn, .receiveIdleFlag, .sendBreakRequest, .breakForceOverride,
  .txPolarityInvert, .txOut
);

//--- sim/ubr_serial_peer.sv
`timescale 1ns/1ps
module ubr_serial_peer (
  input wire logic core_clk,
  output logic rxLine
);
  // rests at mark level, as a pulled-up pin would
  initial rxLine = 1'b1;
  task automatic send(input logic [15:0] data, input int nBits, input int bitLen);
    int i;
    for (i = -1; i <= nBits; i++) begin
      rxLine <= (i < 0) ? 1'b0 : (i == nBits) ? 1'b1 : data[i];
      repeat (bitLen) @(negedge core_clk);
    end
  endtask
endmodule

//--- sim/tb_ubr_baud_core.sv
`timescale 1ns/1ps
module tb_ubr_baud_core;
  localparam logic [9:0] ABD_SET = 10'h200;
  localparam logic [9:0] ABD_CLR = 10'h100;
  localparam logic [9:0] OVF_CLR = 10'h040;
  localparam logic [9:0] WAKE_SET = 10'h020;
  localparam logic [9:0] BRK_SET = 10'h004;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] pls = 10'h000;
  logic [3:0] uartMode;
  logic [7:0] divisorWrData, transmitBufferData, baudDivisorHigh, baudDivisorLow;
  logic baudSpeedSelect, baudDivisorHighWr, baudDivisorLowWr, autobaudOverflowIrqEnable, uartErrorIrqEnable;
  logic peripheralIrqEnable, globalIrqEnable, uartIrqEnable, rxPolarityInvert, transmitEnable;
  logic breakForceOverride, txPolarityInvert, rxIn, autobaudEnable, autobaudDoneFlag, autobaudOverflowFlag;
  logic autobaudOverflowIrq, wakeEnable, wakeFlag, wakeIrq, receiveIdleFlag, baudTick, sendBreakRequest;
  logic txOut, transmitIdleFlag;
  wire logic autobaudEnableSet, autobaudEnableClr, autobaudDoneClr, autobaudOverflowClr, wakeEnableSet;
  wire logic wakeEnableClr, wakeFlagClr, sendBreakSet, sendBreakClr, transmitBufferWrite;
  wire logic [15:0] div = {baudDivisorHigh, baudDivisorLow};
  int num_errors = 0;
  int checks = 0;
  assign {autobaudEnableSet, autobaudEnableClr, autobaudDoneClr, autobaudOverflowClr, wakeEnableSet,
    wakeEnableClr, wakeFlagClr, sendBreakSet, sendBreakClr, transmitBufferWrite} = pls;
  always #50 core_clk = ~core_clk;
  ubr_baud_core i_ubr_baud_core (
    .core_clk, .rst_n, .uartMode, .baudSpeedSelect, .baudDivisorHighWr, .baudDivisorLowWr, .divisorWrData,
    .baudDivisorHigh, .baudDivisorLow, .autobaudEnableSet, .autobaudEnableClr, .autobaudEnable,
    .autobaudDoneClr, .autobaudDoneFlag, .autobaudOverflowClr, .autobaudOverflowFlag,
    .autobaudOverflowIrqEnable, .uartErrorIrqEnable, .peripheralIrqEnable, .globalIrqEnable,
    .autobaudOverflowIrq, .wakeEnableSet, .wakeEnableClr, .wakeEnable, .wakeFlagClr, .wakeFlag,
    .uartIrqEnable, .wakeIrq, .wakeRequest(), .rxIn, .rxPolarityInvert, .receiveIdleFlag, .receiverHold(),
    .baudTick, .transmitEnable, .sendBreakSet, .sendBreakClr, .sendBreakRequest, .breakForceOverride,
    .txPolarityInvert, .transmitBufferWrite, .transmitBufferData, .txOut, .transmitIdleFlag
  );
  ubr_serial_peer i_ubr_serial_peer (
    .core_clk,
    .rxLine(rxIn)
  );
  // ----------------------------------------
  // bench tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input int exp, input logic [15:0] got, input int tol);
    checks++;
    if ($isunknown(got) || got + tol < exp || got > exp + tol) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // bounded: a dead timer ends the run instead of hanging it
  task automatic wt(output int c);
    c = 0;
    do begin
      @(negedge core_clk);
      c++;
    end while (baudTick !== 1'b1 && c < 300);
    if (c >= 300) begin
      num_errors++;
      $display("MISMATCH tick expected pulse seen none");
      test_done();
    end
  endtask
  task automatic pulse(input logic [9:0] m);
    pls = m;
    @(negedge core_clk);
    pls = 10'h000;
    @(negedge core_clk);
  endtask
  task automatic wr_div(input logic [15:0] v);
    divisorWrData = v[7:0];
    baudDivisorLowWr = 1'b1;
    @(negedge core_clk);
    baudDivisorLowWr = 1'b0;
    baudDivisorHighWr = 1'b1;
    divisorWrData = v[15:8];
    @(negedge core_clk);
    baudDivisorHighWr = 1'b0;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int s, n, m, c;
    logic [15:0] old;
    logic [7:0] d;
    logic q[$];
    {uartMode, divisorWrData, transmitBufferData} = '0;
    {baudSpeedSelect, baudDivisorHighWr, baudDivisorLowWr, autobaudOverflowIrqEnable, uartErrorIrqEnable,
      peripheralIrqEnable, globalIrqEnable, uartIrqEnable, rxPolarityInvert, transmitEnable,
      breakForceOverride, txPolarityInvert} = '0;
    s = $urandom(19903);
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk("reset", 16'h0007, {autobaudEnable, autobaudDoneFlag, wakeEnable, wakeFlag, sendBreakRequest,
      receiveIdleFlag, txOut, transmitIdleFlag}, 0);
    for (s = 0; s < 2; s++) begin
      n = s ? 0 : $urandom_range(5, 1);
      baudSpeedSelect = s[0];
      wr_div(16'h0fff);
      wr_div(n[15:0]);
      chk("divisor", n, div, 0);
      wt(c);
      chk("restart", 1, 16'(c <= (s ? 4 : 16) * (n + 1) + 1), 0);
      wt(c);
      chk("period", (s ? 4 : 16) * (n + 1), 16'(c), 0);
    end
    $display("test timer done");
    for (s = 8; s <= 12; s++) begin
      uartMode = s[3:0];
      pulse(ABD_SET | BRK_SET);
      chk("refused", 0, {autobaudEnable, sendBreakRequest}, 0);
    end
    uartMode = 4'h0;
    $display("test modes done");
    {autobaudOverflowIrqEnable, uartErrorIrqEnable} = 2'($urandom);
    {uartIrqEnable, peripheralIrqEnable, globalIrqEnable} = 3'h7;
    old = div;
    m = $urandom_range(40, 8);
    chk("idle before wake", 1, receiveIdleFlag, 0);
    pulse(WAKE_SET | ABD_SET);
    i_ubr_serial_peer.send(16'h0000, 12, 4 * (m + 1));
    chk("wake", 16'h001c, {wakeFlag, wakeIrq, autobaudEnable, wakeEnable, autobaudDoneFlag}, 0);
    fork
      i_ubr_serial_peer.send(16'h0055, 8, 4 * (m + 1));
      begin
        repeat (12 * (m + 1)) @(negedge core_clk);
        chk("measuring", 16'h0001, {receiveIdleFlag, div == old}, 0);
      end
    join
    chk("measured", m, div, 1);
    chk("abd end", 16'h0005, {autobaudDoneFlag, autobaudEnable, receiveIdleFlag}, 0);
    $display("test autobaud done");
    old = div;
    pulse(ABD_SET);
    i_ubr_serial_peer.send(16'h00f0, 8, 8);
    pulse(ABD_CLR);
    pulse(OVF_CLR);
    chk("abort", 16'h0003, {autobaudEnable, autobaudOverflowFlag, receiveIdleFlag, div == old}, 0);
    $display("test abort done");
    wr_div(16'h0001);
    transmitEnable = 1'b1;
    transmitBufferData = 8'($urandom);
    d = transmitBufferData;
    repeat (12) q.push_back(1'b0);
    q.push_back(1'b1);
    q.push_back(1'b0);
    for (s = 0; s < 8; s++) q.push_back(d[s]);
    q.push_back(1'b1);
    pulse(BRK_SET);
    wt(c);
    pls = 10'h001;
    @(negedge core_clk);
    pls = 10'h000;
    for (s = 0; s < 23; s++) begin
      wt(c);
      repeat (4) @(negedge core_clk);
      chk("tx bit", q[s], txOut, 0);
      chk("send break", s < 13, sendBreakRequest, 0);
    end
    wt(c);
    repeat (2) @(negedge core_clk);
    chk("tx idle", 1, transmitIdleFlag, 0);
    breakForceOverride = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("override", 0, txOut, 0);
    breakForceOverride = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("released", 1, txOut, 0);
    $display("test transmit done");
    test_done();
  end
endmodule
